// ### design/flash_command_controller.sv
`timescale 1ns/1ps

module flash_command_controller
#(
  parameter int unsigned ARRAY_WORDS = nvm_cmd_pkg::ARRAY_WORDS_DEFAULT
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic arrayWr,
  input wire logic [16:0] arrayWrAddr,
  input wire logic [15:0] arrayWrData,
  input wire logic arrayWrByte,
  input wire logic cmdWr,
  input wire logic [7:0] cmdWrData,
  input wire logic statWr,
  input wire logic [7:0] statWrData,
  input wire logic divWr,
  input wire logic otherRegWr,
  input wire logic stopMode,
  input wire logic securityOn,
  input wire logic secureSource,
  input wire logic debugMode,
  input wire logic lowProtectDisable,
  input wire logic highProtectDisable,
  input wire logic protectOpen,
  input wire logic [15:0] lowProtectEnd,
  input wire logic [15:0] highProtectStart,
  input wire logic nvmDone,
  input wire logic [15:0] nvmRdData,
  output logic bufferEmpty,
  output logic commandComplete,
  output logic accessError,
  output logic protectionViolation,
  output logic blank,
  output logic dividerLoaded,
  output logic arrayReadBlocked,
  output logic nvmStart,
  output logic nvmAbort,
  output logic [1:0] nvmOp,
  output logic [15:0] nvmAddr,
  output logic [15:0] nvmData
);

  // Last word address visited by erase verify.
  localparam logic [15:0] LAST_WORD = 16'(ARRAY_WORDS - 1);

  // Protection test for one word address.
  function automatic logic inProtected(input logic [15:0] a, input logic [15:0] lowEnd,
                                       input logic [15:0] highStart, input logic lowDis,
                                       input logic highDis, input logic open);
    inProtected = !open || (!lowDis && (a < lowEnd)) || (!highDis && (a >= highStart));
  endfunction

  // Sequence and executor states.
  nvm_cmd_pkg::seq_state_t seqState;
  nvm_cmd_pkg::seq_state_t next_seqState;
  nvm_cmd_pkg::exec_state_t exState;
  // Latched sequence contents.
  logic [15:0] latchAddr;
  logic [15:0] latchData;
  logic [7:0] latchCmd;
  // Queue side signals.
  logic [nvm_cmd_pkg::ENTRY_W-1:0] qOut;
  logic [1:0] pendCount;
  logic qPop;

  ////////////////////////////////////////////////////////////////////////////
  // Sequence decoding.
  wire seqIdle = (seqState == nvm_cmd_pkg::SEQ_IDLE);
  wire seqAddr = (seqState == nvm_cmd_pkg::SEQ_ADDR);
  wire seqCmd = (seqState == nvm_cmd_pkg::SEQ_CMD);
  wire locked = accessError | protectionViolation;
  wire cbeOne = statWrData[nvm_cmd_pkg::STAT_CBE];
  wire running = (exState != nvm_cmd_pkg::EX_IDLE);
  wire isVerify = (cmdWrData == nvm_cmd_pkg::CMD_VERIFY);
  wire isProgram = (cmdWrData == nvm_cmd_pkg::CMD_PROGRAM);
  wire isSector = (cmdWrData == nvm_cmd_pkg::CMD_SECTOR);
  wire isMass = (cmdWrData == nvm_cmd_pkg::CMD_MASS);
  wire validCmd = isVerify | isProgram | isSector | isMass;
  // Untrusted issuer while secured may only mass erase.
  wire secViol = securityOn && !isMass && (!secureSource || debugMode);
  wire anyProtect = !(lowProtectDisable && highProtectDisable && protectOpen);
  wire [15:0] checkAddr = isSector ? (latchAddr & nvm_cmd_pkg::SECTOR_WORD_MASK) : latchAddr;
  wire protHit = inProtected(checkAddr, lowProtectEnd, highProtectStart,
                             lowProtectDisable, highProtectDisable, protectOpen);

  // Individual access error causes; reads have no path here.
  wire errNoDiv = arrayWr && seqIdle && !dividerLoaded;
  wire errAlign = arrayWr && seqIdle && (arrayWrByte || arrayWrAddr[0]);
  wire errBusy = arrayWr && seqIdle && !bufferEmpty;
  wire errAfterAddr = seqAddr && (arrayWr || statWr || divWr || otherRegWr);
  wire errCmdBad = cmdWr && seqAddr && (!validCmd || secViol);
  wire errAfterCmd = seqCmd && (arrayWr || cmdWr || divWr || otherRegWr);
  wire errZero = statWr && seqCmd && !cbeOne;
  wire errStop = stopMode && running;
  wire setAcc = errNoDiv | errAlign | errBusy | errAfterAddr | errCmdBad | errAfterCmd
              | errZero | errStop;

  // Protection violation is judged when the command joins the address.
  wire setPviol = cmdWr && seqAddr && validCmd && !secViol
                && (((isProgram || isSector) && protHit) || (isMass && anyProtect));

  // The launch is the write of one to the empty flag after a clean sequence.
  wire launch = statWr && seqCmd && cbeOne && !locked && !errAfterCmd;
  wire clrAcc = statWr && statWrData[nvm_cmd_pkg::STAT_ACC];
  wire clrPviol = statWr && statWrData[nvm_cmd_pkg::STAT_PROTECTION_VIOLATION_FLAG];
  wire acceptAddr = arrayWr && seqIdle && !errNoDiv && !errAlign && !errBusy;
  wire acceptCmd = cmdWr && seqAddr && !errCmdBad && !setPviol;

  ////////////////////////////////////////////////////////////////////////////
  // Next step of the command write sequence.
  always_comb
  begin
    next_seqState = seqState;
    case (seqState)
      nvm_cmd_pkg::SEQ_IDLE:
      begin
        // Address step.
        if (acceptAddr)
        begin
          next_seqState = nvm_cmd_pkg::SEQ_ADDR;
        end
      end
      nvm_cmd_pkg::SEQ_ADDR:
      begin
        // Command step, or abort on any stray write.
        if (acceptCmd)
        begin
          next_seqState = nvm_cmd_pkg::SEQ_CMD;
        end
        else if (errAfterAddr || errCmdBad || setPviol)
        begin
          next_seqState = nvm_cmd_pkg::SEQ_IDLE;
        end
      end
      nvm_cmd_pkg::SEQ_CMD:
      begin
        // Launch, refusal or abort all end the sequence.
        if (statWr || errAfterCmd)
        begin
          next_seqState = nvm_cmd_pkg::SEQ_IDLE;
        end
      end
      default:
      begin
        next_seqState = nvm_cmd_pkg::SEQ_IDLE;
      end
    endcase
  end

  // Sequence state register.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seqState <= nvm_cmd_pkg::SEQ_IDLE;
    end
    else
    begin
      seqState <= next_seqState;
    end
  end

  // Latches for address, data and command of the sequence.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      latchAddr <= 16'h0000;
      latchData <= 16'h0000;
      latchCmd <= 8'h00;
    end
    else
    begin
      if (acceptAddr)
      begin
        latchAddr <= arrayWrAddr[16:1];
        latchData <= arrayWrData;
      end
      if (acceptCmd)
      begin
        latchCmd <= cmdWrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a setting event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      accessError <= 1'b0;
      protectionViolation <= 1'b0;
      dividerLoaded <= 1'b0;
    end
    else
    begin
      accessError <= setAcc | (accessError & ~clrAcc);
      protectionViolation <= setPviol | (protectionViolation & ~clrPviol);
      dividerLoaded <= dividerLoaded | divWr;
    end
  end

  // Complete flag: cleared by launch, set once nothing runs or waits.
  wire allDone = !running && (pendCount == 2'h0);
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      commandComplete <= nvm_cmd_pkg::CC_RESET;
    end
    else if (errStop)
    begin
      // A stop abort wins, since an entry pushed in the same cycle is flushed.
      commandComplete <= 1'b1;
    end
    else if (launch)
    begin
      commandComplete <= 1'b0;
    end
    else if (allDone)
    begin
      commandComplete <= 1'b1;
    end
  end

  // The buffers are free once the launched entry has moved to the executor.
  assign bufferEmpty = (pendCount == 2'h0);
  // Array reads return invalid data while an algorithm runs.
  assign arrayReadBlocked = !commandComplete;

  ////////////////////////////////////////////////////////////////////////////
  // Queue between the sequence latches and the executor.
  assign qPop = (exState == nvm_cmd_pkg::EX_IDLE) && (pendCount != 2'h0) && !stopMode;

  cmd_queue u_queue
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .push(launch),
    .pushData({latchCmd, latchAddr, latchData}),
    .pop(qPop),
    .flush(errStop),
    .popData(qOut),
    .count(pendCount)
  );

  // Fields of the entry being started.
  wire [7:0] qCmd = qOut[39:32];
  wire [15:0] qAddr = qOut[31:16];
  wire [15:0] qData = qOut[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Executor: starts array operations and runs the blank scan.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      exState <= nvm_cmd_pkg::EX_IDLE;
      nvmStart <= 1'b0;
      nvmAbort <= 1'b0;
      nvmOp <= nvm_cmd_pkg::OP_PROGRAM;
      nvmAddr <= 16'h0000;
      nvmData <= 16'h0000;
      blank <= 1'b0;
    end
    else
    begin
      nvmStart <= 1'b0;
      nvmAbort <= errStop;
      if (launch)
      begin
        blank <= 1'b0;
      end
      if (errStop)
      begin
        // Stop mode kills the running operation at once.
        exState <= nvm_cmd_pkg::EX_IDLE;
      end
      else
      begin
        case (exState)
          nvm_cmd_pkg::EX_IDLE:
          begin
            if (qPop)
            begin
              exState <= nvm_cmd_pkg::EX_LOAD;
            end
          end
          nvm_cmd_pkg::EX_LOAD:
          begin
            nvmData <= qData;
            if (qCmd == nvm_cmd_pkg::CMD_VERIFY)
            begin
              // Address and data of the sequence are ignored.
              nvmAddr <= 16'h0000;
              exState <= nvm_cmd_pkg::EX_VADDR;
            end
            else if (qCmd == nvm_cmd_pkg::CMD_SECTOR)
            begin
              nvmAddr <= qAddr & nvm_cmd_pkg::SECTOR_WORD_MASK;
              nvmOp <= nvm_cmd_pkg::OP_SECTOR;
              nvmStart <= 1'b1;
              exState <= nvm_cmd_pkg::EX_BUSY;
            end
            else if (qCmd == nvm_cmd_pkg::CMD_MASS)
            begin
              nvmAddr <= 16'h0000;
              nvmOp <= nvm_cmd_pkg::OP_MASS;
              nvmStart <= 1'b1;
              exState <= nvm_cmd_pkg::EX_BUSY;
            end
            else
            begin
              nvmAddr <= qAddr;
              nvmOp <= nvm_cmd_pkg::OP_PROGRAM;
              nvmStart <= 1'b1;
              exState <= nvm_cmd_pkg::EX_BUSY;
            end
          end
          nvm_cmd_pkg::EX_BUSY:
          begin
            // The array macro runs its embedded algorithm until done.
            if (nvmDone)
            begin
              exState <= nvm_cmd_pkg::EX_IDLE;
            end
          end
          nvm_cmd_pkg::EX_VADDR:
          begin
            // Read data for nvmAddr is valid in the next cycle.
            exState <= nvm_cmd_pkg::EX_VCHK;
          end
          nvm_cmd_pkg::EX_VCHK:
          begin
            if (nvmRdData != nvm_cmd_pkg::ERASED_WORD)
            begin
              exState <= nvm_cmd_pkg::EX_IDLE;
            end
            else if (nvmAddr == LAST_WORD)
            begin
              blank <= 1'b1;
              exState <= nvm_cmd_pkg::EX_IDLE;
            end
            else
            begin
              nvmAddr <= nvmAddr + 16'h0001;
              exState <= nvm_cmd_pkg::EX_VADDR;
            end
          end
          default:
          begin
            exState <= nvm_cmd_pkg::EX_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the behaviour above.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // A clean launch into an idle executor with no stop in the way.
  sequence s_clean_launch;
    launch && !running && (latchCmd != nvm_cmd_pkg::CMD_VERIFY) ##1 (!stopMode)[*2];
  endsequence
  // A scan step that finds a programmed word.
  sequence s_verify_fail;
    (exState == nvm_cmd_pkg::EX_VCHK) && (nvmRdData != nvm_cmd_pkg::ERASED_WORD) && !stopMode;
  endsequence

  property p_launch_start;
    s_clean_launch |=> nvmStart;
  endproperty
  a_launch_start: assert property (p_launch_start) else $error("launch did not start array");

  property p_verify_fail;
    s_verify_fail |=> (exState == nvm_cmd_pkg::EX_IDLE) && !blank;
  endproperty
  a_verify_fail: assert property (p_verify_fail) else $error("verify kept going or set blank");

  property p_acc_lock;
    accessError && (pendCount == 2'h0) |=> (pendCount == 2'h0);
  endproperty
  a_acc_lock: assert property (p_acc_lock) else $error("launch while access error set");

  property p_pv_lock;
    protectionViolation && (pendCount == 2'h0) |=> (pendCount == 2'h0);
  endproperty
  a_pv_lock: assert property (p_pv_lock) else $error("launch while violation set");

  property p_launch_clears;
    launch && !errStop |=> !commandComplete && !bufferEmpty;
  endproperty
  a_launch_clears: assert property (p_launch_clears) else $error("complete flag not cleared");

  property p_no_div;
    arrayWr && !dividerLoaded |=> accessError && (seqState == nvm_cmd_pkg::SEQ_IDLE);
  endproperty
  a_no_div: assert property (p_no_div) else $error("write before divider not refused");

  property p_misalign;
    arrayWr && seqIdle && (arrayWrByte || arrayWrAddr[0]) |=> accessError;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned write not flagged");

  property p_zero_abort;
    statWr && seqCmd && !cbeOne |=> accessError && bufferEmpty == $past(bufferEmpty);
  endproperty
  a_zero_abort: assert property (p_zero_abort) else $error("zero write did not abort");

  property p_stop;
    stopMode && running |=> accessError && commandComplete && nvmAbort && (pendCount == 2'h0);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not abort cleanly");

  property p_mass_prot;
    cmdWr && seqAddr && isMass && anyProtect && !secViol |=> protectionViolation;
  endproperty
  a_mass_prot: assert property (p_mass_prot) else $error("mass erase under protection");

  property p_sector_mask;
    nvmStart && (nvmOp == nvm_cmd_pkg::OP_SECTOR) |-> (nvmAddr[8:0] == 9'h000);
  endproperty
  a_sector_mask: assert property (p_sector_mask) else $error("sector address not aligned");

  property p_div_sticky;
    divWr |=> dividerLoaded [*3];
  endproperty
  a_div_sticky: assert property (p_div_sticky) else $error("divider flag not held");

endmodule

// ### shared/nvm_cmd_pkg.sv
package nvm_cmd_pkg;

  // Command codes accepted in the command register.
  localparam logic [7:0] CMD_VERIFY = 8'h05;
  localparam logic [7:0] CMD_PROGRAM = 8'h20;
  localparam logic [7:0] CMD_SECTOR = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;

  // Bit positions inside a status register write.
  localparam int STAT_CBE = 7;
  localparam int STAT_PROTECTION_VIOLATION_FLAG = 5;
  localparam int STAT_ACC = 4;

  // Value of an erased array word.
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // A sector is 1024 bytes, so word address bits 8 down to 0 are dropped.
  localparam logic [15:0] SECTOR_WORD_MASK = 16'hFE00;

  // Array size in 16-bit words.
  localparam int unsigned ARRAY_WORDS_DEFAULT = 65536;

  // Width of one queue entry: command, word address and data word.
  localparam int ENTRY_W = 40;

  // Operation codes driven to the array macro.
  localparam logic [1:0] OP_PROGRAM = 2'h0;
  localparam logic [1:0] OP_SECTOR = 2'h1;
  localparam logic [1:0] OP_MASS = 2'h2;

  // Reset value of the command complete flag.
  localparam logic CC_RESET = 1'b1;

  // Steps of the host command write sequence.
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} seq_state_t;

  // Steps of the command executor.
  typedef enum logic [2:0] {EX_IDLE, EX_LOAD, EX_BUSY, EX_VADDR, EX_VCHK} exec_state_t;

endpackage

// ### design/cmd_queue.sv
`timescale 1ns/1ps

// Two-entry store for launched commands with a registered read port.
module cmd_queue
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic push,
  input wire logic [nvm_cmd_pkg::ENTRY_W-1:0] pushData,
  input wire logic pop,
  input wire logic flush,
  output logic [nvm_cmd_pkg::ENTRY_W-1:0] popData,
  output logic [1:0] count
);

  // Storage words; they need no reset because count guards them.
  logic [nvm_cmd_pkg::ENTRY_W-1:0] mem [0:1];
  // Write and read pointers.
  logic wrPtr;
  logic rdPtr;

  ////////////////////////////////////////////////////////////////////////////
  // Storage write.
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wrPtr] <= pushData;
    end
  end

  // Registered read data, so the entry appears one cycle after pop.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      popData <= '0;
    end
    else if (pop)
    begin
      popData <= mem[rdPtr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointers and fill count; flush empties the store at once.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end
    else if (flush)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      wrPtr <= wrPtr ^ push;
      rdPtr <= rdPtr ^ pop;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// ### verification/nvm_array_model.sv
`timescale 1ns/1ps

// Behavioural array macro: takes start pulses and answers with a done pulse.
module nvm_array_model
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic nvmStart,
  input wire logic nvmAbort,
  input wire logic [1:0] nvmOp,
  input wire logic [15:0] nvmAddr,
  input wire logic [15:0] nvmData,
  output logic nvmDone,
  output logic [15:0] nvmRdData
);
  logic [15:0] mem [8]; // Eight words, picked by the low word address bits.
  int left; // Cycles until the running operation ends.

  initial for (int i = 0; i < 8; i++) mem[i] = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////////
  // Applies an operation when it starts and counts down to its done pulse.
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      left <= 0;
      nvmDone <= 1'b0;
      nvmRdData <= 16'h0000;
    end
    else
    begin
      nvmRdData <= mem[nvmAddr[2:0]];
      nvmDone <= (left == 1) && !nvmAbort;
      // An abort ends the operation with no done pulse.
      if (nvmAbort) left <= 0;
      else if (nvmStart) left <= slow ? 20 : 3;
      else if (left > 0) left <= left - 1;
      // Programming can only clear bits; erases set whole words.
      if (nvmStart && nvmOp == nvm_cmd_pkg::OP_PROGRAM) mem[nvmAddr[2:0]] <= mem[nvmAddr[2:0]] & nvmData;
      else if (nvmStart) for (int i = 0; i < 8; i++) mem[i] <= 16'hFFFF;
    end
  end
endmodule

// ### verification/flash_command_controller_bench.sv
`timescale 1ns/1ps

// Self-checking bench: divider check and command rows first, then the verify, error and pipeline cases.
module flash_command_controller_bench;
  typedef struct {logic [7:0] c; logic [16:0] a; logic [15:0] d; logic [1:0] op; logic [15:0] wa; logic ca;} row_t;
  logic clk_sys = 1'b0, arst_n = 1'b0, slow = 1'b0, arrayWr = 1'b0, arrayWrByte = 1'b0, cmdWr = 1'b0;
  logic statWr = 1'b0, divWr = 1'b0, otherRegWr = 1'b0, stopMode = 1'b0, securityOn = 1'b0, secureSource = 1'b1;
  logic lowProtectDisable = 1'b1, highProtectDisable = 1'b1, protectOpen = 1'b1, debugMode = 1'b0;
  logic [16:0] arrayWrAddr = 17'h00000;
  logic [15:0] arrayWrData = 16'h0000, nvmRdData, nvmAddr, nvmData;
  logic [7:0] cmdWrData = 8'h00, statWrData = 8'h00;
  logic bufferEmpty, commandComplete, accessError, protectionViolation, blank, dividerLoaded;
  logic arrayReadBlocked, nvmStart, nvmAbort, nvmDone;
  logic [1:0] nvmOp;
  int fails = 0, n_compared = 0;
  // Mass erase, program, then a sector erase near the top of a sector.
  row_t rows[3] = '{'{8'h41, 17'h00000, 16'h0000, 2'h2, 16'h0000, 1'b0},
    '{8'h20, 17'h00010, 16'h1234, 2'h0, 16'h0008, 1'b1}, '{8'h40, 17'h007FE, 16'h9999, 2'h1, 16'h0200, 1'b1}};

  always #5 clk_sys = ~clk_sys;

  flash_command_controller #(.ARRAY_WORDS(8)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .arrayWr(arrayWr),
    .arrayWrAddr(arrayWrAddr), .arrayWrData(arrayWrData), .arrayWrByte(arrayWrByte), .cmdWr(cmdWr),
    .cmdWrData(cmdWrData), .statWr(statWr), .statWrData(statWrData), .divWr(divWr), .otherRegWr(otherRegWr),
    .stopMode(stopMode), .securityOn(securityOn), .secureSource(secureSource), .debugMode(debugMode),
    .lowProtectDisable(lowProtectDisable), .highProtectDisable(highProtectDisable), .protectOpen(protectOpen),
    .lowProtectEnd(16'h0010), .highProtectStart(16'hFF00), .nvmDone(nvmDone), .nvmRdData(nvmRdData),
    .bufferEmpty(bufferEmpty), .commandComplete(commandComplete), .accessError(accessError),
    .protectionViolation(protectionViolation), .blank(blank), .dividerLoaded(dividerLoaded),
    .arrayReadBlocked(arrayReadBlocked), .nvmStart(nvmStart), .nvmAbort(nvmAbort), .nvmOp(nvmOp),
    .nvmAddr(nvmAddr), .nvmData(nvmData));

  nvm_array_model model (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow), .nvmStart(nvmStart),
    .nvmAbort(nvmAbort), .nvmOp(nvmOp), .nvmAddr(nvmAddr), .nvmData(nvmData), .nvmDone(nvmDone),
    .nvmRdData(nvmRdData));

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task automatic summarize();
    $display("fails=%0d compared=%0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Compares a one-bit flag.
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Compares a 16-bit word.
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One host write: 0 array, 1 command, 2 status, 3 divider, 4 other register.
  task automatic wr(input int k, input logic [16:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    arrayWr <= (k == 0);
    cmdWr <= (k == 1);
    statWr <= (k == 2);
    divWr <= (k == 3);
    otherRegWr <= (k == 4);
    arrayWrAddr <= a;
    arrayWrData <= d;
    cmdWrData <= d[7:0];
    statWrData <= d[7:0];
  endtask

  // Ends a run of writes and lets the last one be taken.
  task automatic idle();
    wr(5, 17'h00000, 16'h0000);
    #1;
  endtask

  // Full three-step sequence.
  task automatic seq(input logic [16:0] a, input logic [15:0] d, input logic [7:0] c);
    wr(0, a, d);
    wr(1, 17'h00000, {8'h00, c});
    wr(2, 17'h00000, 16'h0080);
    idle();
  endtask

  // Clears both error flags by writing ones to them.
  task automatic clearErr();
    wr(2, 17'h00000, 16'h0030);
    idle();
    chk1(accessError, 1'b0);
    chk1(protectionViolation, 1'b0);
  endtask

  // Bounded wait: 0 start pulse, 1 command complete, 2 array done.
  task automatic waitHi(input int w);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (n < 500 && !((w == 0) ? nvmStart === 1'b1 : (w == 1) ? commandComplete === 1'b1 : nvmDone === 1'b1));
    if (n >= 500) fails++;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Stops a hung run well after the tests should have finished.
  initial
  begin
    #100000;
    fails++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
    chk1(bufferEmpty, 1'b1);
    chk1(commandComplete, 1'b1);
    chk1(dividerLoaded, 1'b0);
    chk1(accessError, 1'b0);
    // Array write before any divider write is refused.
    seq(17'h00010, 16'h1234, nvm_cmd_pkg::CMD_PROGRAM);
    chk1(accessError, 1'b1);
    wr(2, 17'h00000, 16'h0000);
    idle();
    chk1(accessError, 1'b1);
    clearErr();
    wr(3, 17'h00000, 16'h0000);
    idle();
    chk1(dividerLoaded, 1'b1);
    // Ordinary commands, one row each.
    foreach (rows[i])
    begin
      seq(rows[i].a, rows[i].d, rows[i].c);
      chk1(commandComplete, 1'b0);
      chk1(arrayReadBlocked, 1'b1);
      @(posedge clk_sys);
      #1;
      chk1(bufferEmpty, 1'b1);
      waitHi(0);
      chk16({14'h0000, nvmOp}, {14'h0000, rows[i].op});
      if (rows[i].ca) chk16(nvmAddr, rows[i].wa);
      if (rows[i].op == nvm_cmd_pkg::OP_PROGRAM) chk16(nvmData, rows[i].d);
      waitHi(1);
    end
    // Erase verify passes on an erased array, then fails on a programmed word.
    seq(17'h00000, 16'h0000, nvm_cmd_pkg::CMD_VERIFY);
    waitHi(1);
    chk1(blank, 1'b1);
    seq(17'h00006, 16'h00FF, nvm_cmd_pkg::CMD_PROGRAM);
    waitHi(1);
    seq(17'h00000, 16'h0000, nvm_cmd_pkg::CMD_VERIFY);
    waitHi(1);
    chk1(blank, 1'b0);
    // Illegal sequences; each then locks out a valid sequence.
    for (int i = 0; i < 14; i++)
    begin
      @(posedge clk_sys);
      arrayWrByte <= (i == 0);
      securityOn <= (i == 7 || i == 12);
      secureSource <= (i != 7);
      debugMode <= (i == 12);
      lowProtectDisable <= !(i == 9 || i == 10);
      highProtectDisable <= (i != 13);
      protectOpen <= (i != 11);
      case (i)
        0: wr(0, 17'h00010, 16'h0001);
        1: wr(0, 17'h00011, 16'h0001);
        2: begin wr(0, 17'h00010, 16'h0001); wr(1, 17'h00000, 16'h0021); end
        3: begin wr(0, 17'h00010, 16'h0001); wr(4, 17'h00000, 16'h0000); end
        4: begin wr(0, 17'h00010, 16'h0001); wr(0, 17'h00012, 16'h0001); end
        5: begin wr(0, 17'h00010, 16'h0001); wr(1, 17'h00000, 16'h0020); wr(1, 17'h00000, 16'h0020); end
        6: begin wr(0, 17'h00010, 16'h0001); wr(1, 17'h00000, 16'h0020); wr(2, 17'h00000, 16'h0000); end
        7: begin wr(0, 17'h00010, 16'h0001); wr(1, 17'h00000, 16'h0020); end
        8: begin wr(0, 17'h00010, 16'h0001); wr(1, 17'h00000, 16'h0020); wr(3, 17'h00000, 16'h0000); end
        9: begin wr(0, 17'h00004, 16'h0001); wr(1, 17'h00000, 16'h0020); end
        10: begin wr(0, 17'h00004, 16'h0001); wr(1, 17'h00000, 16'h0040); end
        11, 13: begin wr(0, 17'h00000, 16'h0000); wr(1, 17'h00000, 16'h0041); end
        default: begin wr(0, 17'h00010, 16'h0001); wr(1, 17'h00000, 16'h0020); end
      endcase
      idle();
      arrayWrByte <= 1'b0;
      chk1(accessError, i < 9 || i == 12);
      chk1(protectionViolation, i >= 9 && i != 12);
      seq(17'h00100, 16'h0F0F, nvm_cmd_pkg::CMD_PROGRAM);
      chk1(commandComplete, 1'b1);
      clearErr();
    end
    securityOn <= 1'b0;
    secureSource <= 1'b1;
    debugMode <= 1'b0;
    highProtectDisable <= 1'b1;
    lowProtectDisable <= 1'b1;
    protectOpen <= 1'b1;
    // Second program queued while the first still runs.
    slow <= 1'b1;
    seq(17'h00008, 16'hAAAA, nvm_cmd_pkg::CMD_PROGRAM);
    @(posedge clk_sys);
    #1;
    chk1(bufferEmpty, 1'b1);
    seq(17'h0000A, 16'h5555, nvm_cmd_pkg::CMD_PROGRAM);
    waitHi(2);
    @(posedge clk_sys);
    #1;
    chk1(commandComplete, 1'b0);
    waitHi(0);
    chk16(nvmAddr, 16'h0005);
    chk16(nvmData, 16'h5555);
    waitHi(1);
    chk16(model.mem[4], 16'hAAAA);
    chk16(model.mem[5], 16'h5555);
    // Array write in the cycle right after a launch, while buffers are busy.
    wr(0, 17'h0000C, 16'h1111);
    wr(1, 17'h00000, 16'h0020);
    wr(2, 17'h00000, 16'h0080);
    wr(0, 17'h0000E, 16'h2222);
    idle();
    chk1(accessError, 1'b1);
    waitHi(1);
    clearErr();
    // Stop mode in mid-program aborts it.
    seq(17'h00010, 16'h0F0F, nvm_cmd_pkg::CMD_PROGRAM);
    waitHi(0);
    @(posedge clk_sys);
    stopMode <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk1(accessError, 1'b1);
    chk1(nvmAbort, 1'b1);
    chk1(commandComplete, 1'b1);
    @(posedge clk_sys);
    stopMode <= 1'b0;
    clearErr();
    summarize();
  end
endmodule
